// ===== dv/tb_twsi_smbus.sv
/* tb_twsi_smbus: directed bench driving the command port as master.
 Assumes one far slave model on a pulled-up pair of lines. */
`timescale 1ns/100ps
`default_nettype none
module tb_twsi_smbus;
localparam logic [6:0] SLV = 7'h3a; // far slave address
localparam logic [7:0] RD = 8'hc3; // byte the far slave returns
logic sys_clk = 0, link_clk = 0, nrst = 0, smbus_enable = 1, slow = 0;
logic slave_event_inhibit = 0, hw_ack_enable = 0;
logic bus_free_timeout_enable = 1, clock_low_timeout_enable = 0;
logic cmd_valid = 0, cmd_ack = 0;
logic [6:0] own_address = 7'h11; // never addressed here
logic [1:0] bit_rate_source_select = 2'h0;
logic [3:0] rate_ticks = 4'h0;
logic [2:0] cmd_code = 3'h0;
logic [7:0] cmd_data = 8'h00, got, d;
logic cmd_ready, evt_valid, evt_ack, bus_busy, scl_timer_run;
logic scl_o, sda_o, scl_oe, sda_oe, m_scl, m_sda;
logic [2:0] evt_code;
logic [7:0] evt_data;
int miscompares = 0, comparisons = 0, tc = 0;
wire scl = !(scl_oe || m_scl); // pull-up unless someone pulls low
wire sda = !(sda_oe || m_sda);
always #20 sys_clk = ~sys_clk;
initial #7 forever #15 link_clk = ~link_clk;
// timer overflows at a different rate per source
always @(negedge sys_clk) begin
	tc <= tc + 1;
	for (int i = 0; i < 4; i++)
		rate_ticks[i] <= (tc % (8 + 2 * i) == 0);
end
twsi_smbus dut (.sys_clk, .nrst, .link_clk, .smbus_enable,
	.slave_event_inhibit, .hw_ack_enable, .own_address,
	.bus_free_timeout_enable, .bit_rate_source_select, .rate_ticks,
	.clock_low_timeout_enable, .cmd_valid, .cmd_code, .cmd_ack, .cmd_data,
	.cmd_ready, .evt_valid, .evt_code, .evt_ack, .evt_data, .bus_busy,
	.scl_timer_run, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
	.sda_oe);
twsi_far_slave #(.SLV(SLV), .RD(RD)) far (.scl, .sda, .slow,
	.scl_pull(m_scl), .sda_pull(m_sda), .got);
////////////////////////////////
task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
	comparisons++;
	if (seen !== exp) begin
		miscompares++;
		$display("unexpected at %0t: %h vs %h", $time, seen, exp);
	end
endtask
task automatic final_report();
	$display("miscompares %0d comparisons %0d", miscompares, comparisons);
	if (miscompares == 0 && comparisons > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
// one command, then wait for its event; waits are bounded
task automatic xfer(input logic [2:0] c, input logic a,
	input logic [7:0] dd, input logic [2:0] ec);
	int n;
	@(negedge sys_clk);
	n = 0;
	while (cmd_ready !== 1'b1 && n < 9000) begin
		@(negedge sys_clk);
		n++;
	end
	if (n >= 9000) miscompares++;
	cmd_code = c;
	cmd_ack = a;
	cmd_data = dd;
	cmd_valid = 1'b1;
	@(negedge sys_clk);
	cmd_valid = 1'b0;
	n = 0;
	while (evt_valid !== 1'b1 && n < 9000) begin
		@(posedge sys_clk);
		#1 n++;
	end
	if (n >= 9000) miscompares++;
	chk({5'h0, evt_code}, {5'h0, ec});
endtask
initial begin
	repeat (80000) @(posedge sys_clk);
	miscompares++;
	final_report();
end
initial begin
	repeat (16) @(negedge sys_clk);
	nrst = 1'b1;
	@(negedge sys_clk);
	chk({3'h0, cmd_ready, scl_oe, sda_oe, scl_o, sda_o}, 8'h10);
	// one write frame per bit-rate source
	for (int s = 0; s < 4; s++) begin
		@(negedge sys_clk);
		bit_rate_source_select = s[1:0];
		d = 8'h96 ^ {6'h0, s[1:0]};
		xfer(twsi_pkg::CMD_START, 1'b0, 8'h00, twsi_pkg::EV_START);
		xfer(twsi_pkg::CMD_TX, 1'b0, {SLV, 1'b0}, twsi_pkg::EV_BYTE);
		chk({7'h0, evt_ack}, 8'h01);
		xfer(twsi_pkg::CMD_TX, 1'b0, d, twsi_pkg::EV_BYTE);
		chk({7'h0, evt_ack}, 8'h01);
		xfer(twsi_pkg::CMD_STOP, 1'b0, 8'h00, twsi_pkg::EV_STOP);
		chk(got, d);
	end
	// nobody answers a foreign address
	xfer(twsi_pkg::CMD_START, 1'b0, 8'h00, twsi_pkg::EV_START);
	xfer(twsi_pkg::CMD_TX, 1'b0, {SLV ^ 7'h01, 1'b0}, twsi_pkg::EV_BYTE);
	chk({7'h0, evt_ack}, 8'h00);
	xfer(twsi_pkg::CMD_STOP, 1'b0, 8'h00, twsi_pkg::EV_STOP);
	// read with a stretching slave, last byte refused
	@(negedge sys_clk);
	slow = 1'b1;
	clock_low_timeout_enable = 1'b1;
	xfer(twsi_pkg::CMD_START, 1'b0, 8'h00, twsi_pkg::EV_START);
	xfer(twsi_pkg::CMD_TX, 1'b0, {SLV, 1'b1}, twsi_pkg::EV_BYTE);
	chk({7'h0, evt_ack}, 8'h01);
	xfer(twsi_pkg::CMD_RX, 1'b1, 8'h00, twsi_pkg::EV_BYTE);
	chk(evt_data, RD);
	chk({7'h0, evt_ack}, 8'h01);
	// the slave sent one byte only: the released line reads ones
	xfer(twsi_pkg::CMD_RX, 1'b0, 8'h00, twsi_pkg::EV_BYTE);
	chk(evt_data, 8'hff);
	chk({7'h0, evt_ack}, 8'h00);
	xfer(twsi_pkg::CMD_STOP, 1'b0, 8'h00, twsi_pkg::EV_STOP);
	repeat (60) @(negedge sys_clk);
	chk({7'h0, bus_busy}, 8'h00);
	// abandon a frame after its start: scl rises alone, no stop seen
	xfer(twsi_pkg::CMD_START, 1'b0, 8'h00, twsi_pkg::EV_START);
	repeat (4) @(negedge sys_clk);
	chk({5'h0, bus_busy, scl_oe, scl_timer_run}, 8'h07);
	smbus_enable = 1'b0;
	repeat (10) @(negedge sys_clk);
	chk({4'h0, bus_busy, scl_oe, sda_oe, scl_timer_run}, 8'h08);
	// only the free timeout can clear busy now
	repeat (200) @(negedge sys_clk);
	chk({7'h0, bus_busy}, 8'h00);
	final_report();
end
endmodule // tb_twsi_smbus
`default_nettype wire

// ===== dv/twsi_far_slave.sv
/* twsi_far_slave: behavioural slave on the far side of the bus.
 Assumes pulled-up lines; it only ever pulls low, one data byte a frame. */
`timescale 1ns/100ps
`default_nettype none
module twsi_far_slave #(
	parameter logic [6:0] SLV = 7'h3a, // address it answers to
	parameter logic [7:0] RD = 8'hc3 // byte it sends on a read
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic slow,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] got
);
logic [7:0] b; // shift register
////////////////////////////////
// eight bits in, msb first, sampled on rising clock
task automatic take();
	repeat (8) @(posedge scl) b = {b[6:0], sda};
endtask
// ack slot; slow mode stretches the low clock to test tolerance
task automatic ack();
	@(negedge scl) #5 sda_pull = 1'b1;
	if (slow) begin
		scl_pull = 1'b1;
		#3000 scl_pull = 1'b0;
	end
endtask
initial begin
	scl_pull = 1'b0;
	sda_pull = 1'b0;
	got = 8'h00;
	forever begin
		@(negedge sda iff scl);
		take();
		// foreign address: stay off the bus until the next start
		if (b[7:1] !== SLV)
			continue;
		ack();
		if (b[0]) begin
			for (int i = 7; i >= 0; i--)
				@(negedge scl) #5 sda_pull = !RD[i];
			@(negedge scl) #5 sda_pull = 1'b0;
		end else begin
			@(negedge scl) #5 sda_pull = 1'b0;
			take();
			got = b;
			ack();
			@(negedge scl) #5 sda_pull = 1'b0;
		end
	end
end
endmodule // twsi_far_slave
`default_nettype wire

// ===== dv/twsi_smbus_props.sv
/* twsi_smbus_props: port checks of the two-wire engine.
 Assumes it is bound onto twsi_smbus and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module twsi_smbus_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic smbus_enable,
	input wire logic clock_low_timeout_enable,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic evt_valid,
	input wire logic [2:0] evt_code,
	input wire logic [7:0] evt_data,
	input wire logic bus_busy,
	input wire logic scl_timer_run,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic scl_oe,
	input wire logic sda_oe
);
////////////////////////////////
// open drain: the driven level is only ever low
AST_SCL_ZERO: assert property (@(posedge link_clk) disable iff (!nrst)
	!scl_o) else $error("scl output level high");
AST_SDA_ZERO: assert property (@(posedge link_clk) disable iff (!nrst)
	!sda_o) else $error("sda output level high");
// a disabled engine lets go of both lines
AST_OFF_FREE: assert property (@(posedge link_clk) disable iff (!nrst)
	(!smbus_enable) [*8] |-> !scl_oe && !sda_oe)
	else $error("lines held while disabled");
// a taken command blocks the next one while it crosses
AST_RDY_DROP: assert property (@(posedge sys_clk) disable iff (!nrst)
	cmd_valid && cmd_ready |=> !cmd_ready ##1 !cmd_ready)
	else $error("ready did not drop");
AST_EVT_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
	evt_valid |=> !evt_valid) else $error("event pulse too long");
// event word stands between pulses so software can read it late
AST_EVT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
	!evt_valid |-> $stable(evt_code) && $stable(evt_data))
	else $error("event word moved");
AST_TMR_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
	(!clock_low_timeout_enable) [*4] |-> !scl_timer_run)
	else $error("low timer runs while off");
// a start seen on the wire marks the bus busy
AST_START_BUSY: assert property (@(posedge sys_clk) disable iff (!nrst)
	scl_i && $fell(sda_i) |-> ##[1:12] bus_busy)
	else $error("start not flagged busy");
COV_BYTE: cover property (@(posedge sys_clk) evt_valid && evt_code == 3'h1);
COV_STOP: cover property (@(posedge sys_clk) evt_valid && evt_code == 3'h3);
COV_TMR: cover property (@(posedge sys_clk) scl_timer_run);
endmodule // twsi_smbus_props
bind twsi_smbus twsi_smbus_props u_props (.sys_clk, .nrst, .link_clk,
	.smbus_enable, .clock_low_timeout_enable, .cmd_valid, .cmd_ready,
	.evt_valid, .evt_code, .evt_data, .bus_busy, .scl_timer_run, .scl_i,
	.sda_i, .scl_o, .sda_o, .scl_oe, .sda_oe);
`default_nettype wire

// ===== logic/twsi_hs.sv
/*
 twsi_hs: toggle handshake carrying one word between two clock domains.
 Assumes the source never requests while src_busy is high.
*/
`timescale 1ns/100ps
`default_nettype none
module twsi_hs #(parameter int W = 12) (
	input wire logic src_clk,
	input wire logic dst_clk,
	input wire logic nrst,
	twsi_hs_if.core hs
);
	logic req_r, req_nxt;           // source request toggle
	logic [W-1:0] hold_r, hold_nxt; // word held stable while busy
	logic ack1_r, ack2_r;           // ack toggle synchroniser
	logic rq1_r, rq2_r, rq3_r;      // request synchroniser + history
	logic dv_r, dv_nxt;             // destination pulse
	logic [W-1:0] dd_r, dd_nxt;     // destination word

	// busy until the toggle has made the round trip
	assign hs.src_busy = req_r ^ ack2_r;
	assign hs.dst_valid = dv_r;
	assign hs.dst_data = dd_r;

	////////////////////////////////////////////////////////////////////
	// source side
	always_comb begin
		req_nxt = req_r;
		hold_nxt = hold_r;
		if (hs.src_valid && !hs.src_busy) begin
			req_nxt = ~req_r;
			hold_nxt = hs.src_data;
		end
	end

	always_ff @(posedge src_clk or negedge nrst) begin
		if (!nrst) begin
			req_r <= 1'b0;
			hold_r <= '0;
			ack1_r <= 1'b0;
			ack2_r <= 1'b0;
		end else begin
			req_r <= req_nxt;
			hold_r <= hold_nxt;
			ack1_r <= rq3_r; // first stage, read only by ack2_r
			ack2_r <= ack1_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// destination side: hold_r is stable while the toggle travels
	always_comb begin
		dv_nxt = rq2_r ^ rq3_r;
		dd_nxt = (rq2_r ^ rq3_r) ? hold_r : dd_r;
	end

	always_ff @(posedge dst_clk or negedge nrst) begin
		if (!nrst) begin
			rq1_r <= 1'b0;
			rq2_r <= 1'b0;
			rq3_r <= 1'b0;
			dv_r <= 1'b0;
			dd_r <= '0;
		end else begin
			rq1_r <= req_r;
			rq2_r <= rq1_r;
			rq3_r <= rq2_r;
			dv_r <= dv_nxt;
			dd_r <= dd_nxt;
		end
	end
endmodule // twsi_hs
`default_nettype wire

// ===== logic/twsi_hs_if.sv
/*
 twsi_hs_if: carrier of one word crossing between two clock domains.
 Assumes the user side drives src_* on the source clock and reads dst_*
 on the destination clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface twsi_hs_if #(parameter int W = 12);
	logic src_valid;         // one-cycle request, source clock
	logic [W-1:0] src_data;  // word sampled with src_valid
	logic src_busy;          // crossing in flight, requests ignored
	logic dst_valid;         // one-cycle pulse, destination clock
	logic [W-1:0] dst_data;  // word, stands until the next pulse
	modport core(input src_valid, input src_data, output src_busy,
		output dst_valid, output dst_data);
	modport user(output src_valid, output src_data, input src_busy,
		input dst_valid, input dst_data);
endinterface
`default_nettype wire

// ===== logic/twsi_pkg.sv
/*
 twsi_pkg: constants and types shared by the two-wire serial interface.
 Assumes nothing of its surroundings; imported by full scope name only.
*/
`default_nettype none
package twsi_pkg;
	// byte and word layout of the command and event words
	localparam int DATA_W = 8;           // bits per serial byte
	localparam int ADDR_W = 7;           // slave address width
	localparam int CODE_W = 3;           // command / event code width
	localparam int WORD_W = 12;          // code + ack + data
	localparam int ACK_POS = 8;          // ack bit position in a word
	localparam int CODE_LSB = 9;         // code field lsb in a word
	localparam logic [3:0] ACK_SLOT = 4'h8;   // bit count of the ninth clock
	localparam logic [3:0] FREE_TICKS = 4'ha; // free when exceeded
	localparam int CFG_W = 11;           // config bits sent to link side
	localparam int RATE_SRC = 4;         // selectable bit-rate sources

	// commands from software
	localparam logic [2:0] CMD_START = 3'h0; // master start condition
	localparam logic [2:0] CMD_TX = 3'h1;    // send a byte
	localparam logic [2:0] CMD_RX = 3'h2;    // receive a byte / ack choice
	localparam logic [2:0] CMD_STOP = 3'h3;  // master stop condition

	// events back to software
	localparam logic [2:0] EV_START = 3'h0;  // master start done
	localparam logic [2:0] EV_BYTE = 3'h1;   // data byte moved
	localparam logic [2:0] EV_ADDR = 3'h2;   // address byte received
	localparam logic [2:0] EV_STOP = 3'h3;   // stop sent or seen
	localparam logic [2:0] EV_LOST = 3'h4;   // arbitration lost

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,   // bus released
		ST_MSTART = 4'h1, // master: sda low, scl high
		ST_MLOW = 4'h2,   // master: scl low phase
		ST_MHIGH = 4'h3,  // master: scl high phase
		ST_MHOLD = 4'h4,  // master: scl held low between bytes
		ST_MSTOP1 = 4'h5, // master: both low before stop
		ST_MSTOP2 = 4'h6, // master: scl high, sda low
		ST_SBITS = 4'h7,  // slave: following the master clock
		ST_SHOLD = 4'h8,  // slave: scl stretched, awaiting software
		ST_SREL = 4'h9    // slave: data set up, about to release scl
	} twsi_state_t;
endpackage
`default_nettype wire

// ===== logic/twsi_smbus.sv
/*
 twsi_smbus: byte-wide two-wire (smbus / i2c) master and slave engine.
 Assumes open-drain pads outside resolve scl/sda from the enables, and
 timer overflow pulses on rate_ticks arrive on sys_clk. The bus engine
 runs on link_clk, which must run freely and well above the bus rate.
*/
`timescale 1ns/100ps
`default_nettype none
module twsi_smbus (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic smbus_enable,
	input wire logic slave_event_inhibit,
	input wire logic hw_ack_enable,
	input wire logic [6:0] own_address,
	input wire logic bus_free_timeout_enable,
	input wire logic [1:0] bit_rate_source_select,
	input wire logic [3:0] rate_ticks,
	input wire logic clock_low_timeout_enable,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic cmd_ack,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic evt_valid,
	output logic [2:0] evt_code,
	output logic evt_ack,
	output logic [7:0] evt_data,
	output logic bus_busy,
	output logic scl_timer_run,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	twsi_hs_if #(.W(twsi_pkg::WORD_W)) cmd_if(); // sys -> link
	twsi_hs_if #(.W(twsi_pkg::WORD_W)) evt_if(); // link -> sys

	////////////////////////////////////////////////////////////////////
	// sys_clk side: commands in, events out, rate tick toggle
	logic cmd_ready_r, cmd_ready_nxt;   // free to take a command
	logic evt_valid_r;                  // event pulse
	logic [11:0] evt_word_r;            // last event word
	logic tick_tg_r, tick_tg_nxt;       // toggles per selected overflow
	logic sclsys1_r, sclsys2_r;         // scl pin into sys domain
	logic busy1_r, busy2_r;             // bus busy level into sys
	logic run_r, run_nxt;               // timeout timer may count
	logic bus_busy_r, bus_busy_nxt;     // link side busy flag

	assign cmd_if.src_valid = cmd_valid && cmd_ready_r;
	assign cmd_if.src_data = {cmd_code, cmd_ack, cmd_data};

	// the same block serves either instance: which timers feed
	// rate_ticks and the timeout timer is wiring outside
	always_comb begin
		cmd_ready_nxt = !cmd_if.src_busy && !cmd_if.src_valid;
		tick_tg_nxt = tick_tg_r ^ rate_ticks[bit_rate_source_select];
		// timer reloads while scl high, counts while low
		run_nxt = clock_low_timeout_enable && !sclsys2_r;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_ready_r <= 1'b0;
			evt_valid_r <= 1'b0;
			evt_word_r <= '0;
			tick_tg_r <= 1'b0;
			sclsys1_r <= 1'b1;
			sclsys2_r <= 1'b1;
			busy1_r <= 1'b0;
			busy2_r <= 1'b0;
			run_r <= 1'b0;
		end else begin
			cmd_ready_r <= cmd_ready_nxt;
			evt_valid_r <= evt_if.dst_valid;
			evt_word_r <= evt_if.dst_data;
			tick_tg_r <= tick_tg_nxt;
			sclsys1_r <= scl_i;
			sclsys2_r <= sclsys1_r;
			busy1_r <= bus_busy_r;
			busy2_r <= busy1_r;
			run_r <= run_nxt;
		end
	end

	assign cmd_ready = cmd_ready_r;
	assign evt_valid = evt_valid_r;
	assign evt_code = evt_word_r[twsi_pkg::CODE_LSB +: twsi_pkg::CODE_W];
	assign evt_ack = evt_word_r[twsi_pkg::ACK_POS];
	assign evt_data = evt_word_r[twsi_pkg::DATA_W-1:0];
	assign bus_busy = busy2_r;
	assign scl_timer_run = run_r;

	twsi_hs #(.W(twsi_pkg::WORD_W)) u_cmd_hs (
		.src_clk(sys_clk),
		.dst_clk(link_clk),
		.nrst(nrst),
		.hs(cmd_if.core)
	);
	twsi_hs #(.W(twsi_pkg::WORD_W)) u_evt_hs (
		.src_clk(link_clk),
		.dst_clk(sys_clk),
		.nrst(nrst),
		.hs(evt_if.core)
	);

	////////////////////////////////////////////////////////////////////
	// link_clk side: synchronisers
	logic scl1_r, scl2_r, scl3_r;   // scl sync + history
	logic sda1_r, sda2_r, sda3_r;   // sda sync + history
	logic tk1_r, tk2_r, tk3_r;      // tick toggle sync + history
	logic [10:0] cfg1_r, cfg2_r;    // quasi-static config levels
	logic tick, scl_rise, scl_fall, start_det, stop_det;
	logic cfg_en, cfg_inh, cfg_hw, cfg_fte;
	logic [6:0] cfg_addr;

	// config is assumed steady around changes; a torn multi-bit
	// update lasts one link cycle only
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			{scl1_r, scl2_r, scl3_r} <= 3'h7;
			{sda1_r, sda2_r, sda3_r} <= 3'h7;
			{tk1_r, tk2_r, tk3_r} <= 3'h0;
			cfg1_r <= '0;
			cfg2_r <= '0;
		end else begin
			{scl1_r, scl2_r, scl3_r} <= {scl_i, scl1_r, scl2_r};
			{sda1_r, sda2_r, sda3_r} <= {sda_i, sda1_r, sda2_r};
			{tk1_r, tk2_r, tk3_r} <= {tick_tg_r, tk1_r, tk2_r};
			cfg1_r <= {smbus_enable, slave_event_inhibit, hw_ack_enable,
				bus_free_timeout_enable, own_address};
			cfg2_r <= cfg1_r;
		end
	end

	assign {cfg_en, cfg_inh, cfg_hw, cfg_fte, cfg_addr} = cfg2_r;
	// one overflow tick; rate limited by the crossing itself
	assign tick = tk2_r ^ tk3_r;
	assign scl_rise = scl2_r && !scl3_r;
	assign scl_fall = !scl2_r && scl3_r;
	assign start_det = scl2_r && scl3_r && sda3_r && !sda2_r;
	assign stop_det = scl2_r && scl3_r && !sda3_r && sda2_r;

	////////////////////////////////////////////////////////////////////
	// link_clk side: bus engine
	twsi_pkg::twsi_state_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;      // bits done in this byte
	logic [7:0] sh_r, sh_nxt;        // shift register, msb first
	logic tx_r, tx_nxt;              // we send this byte
	logic acko_r, acko_nxt;          // ack we will give
	logic acki_r, acki_nxt;          // ack we saw
	logic addr_r, addr_nxt;          // byte is an address
	logic inh_r, inh_nxt;            // slave events inhibited
	logic ackph_r, ackph_nxt;        // slave is in the ninth clock
	logic pre_r, pre_nxt;            // slave hold is before the ack
	logic arm_r, arm_nxt;            // one tick seen in this phase
	logic [3:0] free_r, free_nxt;    // ticks with both lines high
	logic pend_r, pend_nxt;          // command waiting
	logic [11:0] cq_r, cq_nxt;       // waiting command word
	logic ev_v_r, ev_v_nxt;          // event request
	logic [11:0] ev_r, ev_nxt;       // event word
	logic scl_oe_r, scl_oe_nxt;      // pull scl low
	logic sda_oe_r, sda_oe_nxt;      // pull sda low
	logic pin_lo_r;                  // pin level when enabled
	logic take, drv, done;
	logic [2:0] cc;

	always_comb begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		tx_nxt = tx_r;
		acko_nxt = acko_r;
		acki_nxt = acki_r;
		addr_nxt = addr_r;
		inh_nxt = inh_r;
		ackph_nxt = ackph_r;
		pre_nxt = pre_r;
		arm_nxt = arm_r | tick;
		ev_v_nxt = 1'b0;
		ev_nxt = ev_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		bus_busy_nxt = bus_busy_r;
		free_nxt = free_r;
		take = 1'b0;
		done = tick && arm_r;            // a full tick period passed
		cc = cq_r[twsi_pkg::CODE_LSB +: twsi_pkg::CODE_W];
		// level for sda: sender owns bits, receiver the ack slot
		drv = tx_r ? (bit_r < twsi_pkg::ACK_SLOT && !sh_r[7])
			: (bit_r == twsi_pkg::ACK_SLOT && acko_r);
		case (st_r)
			twsi_pkg::ST_IDLE: begin
				scl_oe_nxt = 1'b0;
				sda_oe_nxt = 1'b0;
				// a start waits for a free bus; other commands drop
				if (pend_r && (cc != twsi_pkg::CMD_START || !bus_busy_r)) begin
					take = 1'b1;
					if (cc == twsi_pkg::CMD_START && cfg_en) begin
						st_nxt = twsi_pkg::ST_MSTART;
						sda_oe_nxt = 1'b1;
						arm_nxt = 1'b0;
					end
				end
			end
			twsi_pkg::ST_MSTART: if (done) begin
				scl_oe_nxt = 1'b1;
				st_nxt = twsi_pkg::ST_MHOLD;
				ev_v_nxt = 1'b1;
				ev_nxt = {twsi_pkg::EV_START, 1'b0, sh_r};
			end
			twsi_pkg::ST_MHOLD: begin
				// scl kept low until software decides
				scl_oe_nxt = 1'b1;
				sda_oe_nxt = 1'b0;
				arm_nxt = 1'b0;
				if (pend_r) begin
					take = 1'b1;
					bit_nxt = 4'h0;
					addr_nxt = 1'b0;
					if (cc == twsi_pkg::CMD_TX) begin
						sh_nxt = cq_r[7:0];
						tx_nxt = 1'b1;
						st_nxt = twsi_pkg::ST_MLOW;
					end else if (cc == twsi_pkg::CMD_RX) begin
						tx_nxt = 1'b0;
						acko_nxt = cq_r[twsi_pkg::ACK_POS];
						st_nxt = twsi_pkg::ST_MLOW;
					end else if (cc == twsi_pkg::CMD_STOP) begin
						sda_oe_nxt = 1'b1;
						st_nxt = twsi_pkg::ST_MSTOP1;
					end
				end
			end
			twsi_pkg::ST_MLOW: begin
				// change sda only once scl is seen low
				if (!scl2_r) begin
					sda_oe_nxt = drv;
				end
				if (done) begin
					scl_oe_nxt = 1'b0;
					arm_nxt = 1'b0;
					st_nxt = twsi_pkg::ST_MHIGH;
				end
			end
			twsi_pkg::ST_MHIGH: begin
				// high time counts only from scl really high
				if (!scl2_r) begin
					arm_nxt = 1'b0;
				end
				if (scl2_r && done) begin
					sh_nxt = {sh_r[6:0], sda2_r};
					arm_nxt = 1'b0;
					if (tx_r && !sda_oe_r && !sda2_r
						&& bit_r < twsi_pkg::ACK_SLOT) begin
						// sent a one, saw a zero: step back
						tx_nxt = 1'b0;
						sda_oe_nxt = 1'b0;
						bit_nxt = bit_r + 4'h1;
						ackph_nxt = 1'b0;
						st_nxt = twsi_pkg::ST_SBITS;
						ev_v_nxt = 1'b1;
						ev_nxt = {twsi_pkg::EV_LOST, 1'b0, sh_nxt};
					end else if (bit_r == twsi_pkg::ACK_SLOT) begin
						sh_nxt = sh_r;
						acki_nxt = !sda2_r;
						scl_oe_nxt = 1'b1;
						st_nxt = twsi_pkg::ST_MHOLD;
						ev_v_nxt = 1'b1;
						ev_nxt = {twsi_pkg::EV_BYTE, !sda2_r, sh_r};
					end else begin
						bit_nxt = bit_r + 4'h1;
						scl_oe_nxt = 1'b1;
						st_nxt = twsi_pkg::ST_MLOW;
					end
				end
			end
			twsi_pkg::ST_MSTOP1: if (done) begin
				scl_oe_nxt = 1'b0;
				arm_nxt = 1'b0;
				st_nxt = twsi_pkg::ST_MSTOP2;
			end
			twsi_pkg::ST_MSTOP2: begin
				if (!scl2_r) begin
					arm_nxt = 1'b0;
				end
				if (scl2_r && done) begin
					sda_oe_nxt = 1'b0;
					st_nxt = twsi_pkg::ST_IDLE;
					ev_v_nxt = 1'b1;
					ev_nxt = {twsi_pkg::EV_STOP, acki_r, sh_r};
				end
			end
			twsi_pkg::ST_SBITS: begin
				scl_oe_nxt = 1'b0;
				if (!scl2_r) begin
					sda_oe_nxt = drv;
				end
				if (scl_rise && bit_r < twsi_pkg::ACK_SLOT) begin
					sh_nxt = {sh_r[6:0], sda2_r};
					bit_nxt = bit_r + 4'h1;
				end else if (scl_rise) begin
					acki_nxt = !sda2_r;
				end
				if (scl_fall && bit_r == twsi_pkg::ACK_SLOT && !ackph_r) begin
					ackph_nxt = 1'b1;
					if (!tx_r) begin
						if (inh_r || (addr_r && cfg_hw
							&& sh_r[7:1] != cfg_addr)) begin
							acko_nxt = 1'b0;
							st_nxt = twsi_pkg::ST_IDLE;
						end else if (cfg_hw) begin
							acko_nxt = 1'b1;
						end else begin
							// software picks the ack, scl held
							st_nxt = twsi_pkg::ST_SHOLD;
							scl_oe_nxt = 1'b1;
							pre_nxt = 1'b1;
							ev_v_nxt = 1'b1;
							ev_nxt = {addr_r ? twsi_pkg::EV_ADDR
								: twsi_pkg::EV_BYTE, 1'b0, sh_r};
						end
					end
				end else if (scl_fall && ackph_r) begin
					ackph_nxt = 1'b0;
					bit_nxt = 4'h0;
					addr_nxt = 1'b0;
					acko_nxt = 1'b0;
					if (addr_r) begin
						tx_nxt = sh_r[0];
					end
					if (tx_r && !acki_r) begin
						// master said no more: wait for its stop
						st_nxt = twsi_pkg::ST_IDLE;
					end else if (tx_r || sh_r[0] && addr_r || cfg_hw) begin
						st_nxt = twsi_pkg::ST_SHOLD;
						scl_oe_nxt = 1'b1;
						pre_nxt = 1'b0;
						ev_v_nxt = 1'b1;
						ev_nxt = {addr_r ? twsi_pkg::EV_ADDR
							: twsi_pkg::EV_BYTE, acki_r, sh_r};
					end
				end
			end
			twsi_pkg::ST_SHOLD: begin
				scl_oe_nxt = 1'b1;
				if (pend_r) begin
					take = 1'b1;
					st_nxt = twsi_pkg::ST_SREL;
					if (pre_r) begin
						acko_nxt = cq_r[twsi_pkg::ACK_POS];
					end else if (cc == twsi_pkg::CMD_TX) begin
						sh_nxt = cq_r[7:0];
					end
				end
			end
			twsi_pkg::ST_SREL: begin
				// sda is set and scl is let go on the same link_clk edge
				sda_oe_nxt = drv;
				scl_oe_nxt = 1'b0;
				st_nxt = twsi_pkg::ST_SBITS;
			end
			default: st_nxt = twsi_pkg::ST_IDLE;
		endcase
		// bus watching, in every state
		if (start_det) begin
			bus_busy_nxt = 1'b1;
		end else if (stop_det) begin
			bus_busy_nxt = 1'b0;
		end
		free_nxt = (scl2_r && sda2_r && cfg_fte && !start_det)
			? free_r + {3'h0, tick && free_r <= twsi_pkg::FREE_TICKS}
			: 4'h0;
		// a start in the same cycle wins over the free timeout
		if (free_r > twsi_pkg::FREE_TICKS && !start_det) begin
			bus_busy_nxt = 1'b0;
		end
		if (st_r == twsi_pkg::ST_IDLE || st_r == twsi_pkg::ST_SBITS
			|| st_r == twsi_pkg::ST_SHOLD || st_r == twsi_pkg::ST_SREL) begin
			if (start_det && cfg_en) begin
				st_nxt = twsi_pkg::ST_SBITS;
				bit_nxt = 4'h0;
				tx_nxt = 1'b0;
				addr_nxt = 1'b1;
				ackph_nxt = 1'b0;
				inh_nxt = cfg_inh;
				scl_oe_nxt = 1'b0;
				sda_oe_nxt = 1'b0;
			end else if (stop_det) begin
				if (st_r != twsi_pkg::ST_IDLE && !inh_r) begin
					ev_v_nxt = 1'b1;
					ev_nxt = {twsi_pkg::EV_STOP, 1'b0, sh_r};
				end
				st_nxt = twsi_pkg::ST_IDLE;
			end
		end
		if (!cfg_en) begin
			st_nxt = twsi_pkg::ST_IDLE;
			scl_oe_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
		end
		pend_nxt = cmd_if.dst_valid || (pend_r && !take);
		cq_nxt = cmd_if.dst_valid ? cmd_if.dst_data : cq_r;
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= twsi_pkg::ST_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			{tx_r, acko_r, acki_r, addr_r, inh_r} <= 5'h00;
			{ackph_r, pre_r, arm_r, pend_r, ev_v_r} <= 5'h00;
			free_r <= 4'h0;
			cq_r <= 12'h000;
			ev_r <= 12'h000;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			bus_busy_r <= 1'b0;
			pin_lo_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			{tx_r, acko_r, acki_r, addr_r, inh_r} <=
				{tx_nxt, acko_nxt, acki_nxt, addr_nxt, inh_nxt};
			{ackph_r, pre_r, arm_r, pend_r, ev_v_r} <=
				{ackph_nxt, pre_nxt, arm_nxt, pend_nxt, ev_v_nxt};
			free_r <= free_nxt;
			cq_r <= cq_nxt;
			ev_r <= ev_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			bus_busy_r <= bus_busy_nxt;
			pin_lo_r <= 1'b0; // open drain: only ever low
		end
	end

	assign evt_if.src_valid = ev_v_r;
	assign evt_if.src_data = ev_r;
	assign scl_o = pin_lo_r;
	assign sda_o = pin_lo_r;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
endmodule // twsi_smbus
`default_nettype wire
